// ### core/fram_defs.svh
// Constants for the serial nonvolatile memory slave
`ifndef FRAM_DEFS_SVH
`define FRAM_DEFS_SVH
`define OP_LATCH_SET    8'h06
`define OP_LATCH_CLEAR  8'h04
`define OP_STATUS_READ  8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_READ         8'h03
`define OP_FAST_READ    8'h0b
`define OP_WRITE        8'h02
`define ADDR_W          15
`define ADDR_LAST       15'h7fff
`define ADDR_ZERO       15'h0000
`define QUARTER_BASE    15'h6000
`define HALF_BASE       15'h4000
`define BIT_WEL         1
`define BIT_BP_LO       2
`define BIT_BP_HI       3
`define BIT_PROTECT_PIN_ENABLE        7
`define BIT_LAST        3'h7
`endif

// ### core/fram_pkg.sv
// Types for the serial nonvolatile memory slave
package fram_pkg;
   typedef enum logic [2:0] {
      ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO, ST_DUMMY, ST_WRITE_DATA, ST_READ_DATA,
      ST_STATUS_WR, ST_IGNORE
   } phase_type;
endpackage : fram_pkg

// ### core/spi_fram_protect_and_access.sv
// Command, write-protection and array-access logic of a 32K x 8 serial memory slave
// Operation
// (R1) Write-disable command clears the write enable latch, refusing later writes.
// (R2) Status bits 0 and 4-6 always read zero and cannot be written.
// (R3) Write enable latch is zero after power-up.
// (R4) Status write never sets latch; only set-command sets it.
// (R5) Block-protect bits are retained across power loss.
// (R6) Block-protect codes select none, upper quarter, upper half or whole array.
// (R7) Protect pin counts only when enable bit set; low then blocks status writes.
// (R8) Array byte written only with latch set and address unprotected; pin ignored.
// (R9) Status-read shifts out one status byte.
// (R10) Accepted status write updates enable and block bits, then clears latch.
// (R11) Master holds protect pin high and sends set-command in separate frame.
// (R12) Array write starts with set-command frame; write opcode in new frame.
// (R13) Write opcode, two address bytes (top bit ignored), then MSB-first data.
// (R14) Write address advances and wraps 7FFFh to 0000h; rising select ends.
// (R15) Each data byte committed at its eighth bit, no page buffer.
// (R16) Burst reaching protected address stops incrementing and drops further bytes.
// (R17) Read opcode plus address, data MSB first, input ignored, sequential wrap.
// (R18) Rising chip select ends read and floats serial output.
// (R19) Fast read 0Bh adds one dummy byte of eight clocks latency.
// (R20) Fast read streams sequential bytes with wrap until select rises.
// (R21) Opcodes 06h set, 04h clear, 05h status read; first byte of frame.
// (R22) Latch clears at select rise after clear, status write or array write.
// (R23) Input sampled on rising serial clock, output changed on falling edge.
// (R24) Status write 01h, read 03h, write 02h; other opcodes ignored.
`timescale 1ns/1ps
`include "fram_defs.svh"

module spi_fram_protect_and_access (
   // System
   input  wire logic       clk,
   input  wire logic       rst,
   // Serial link pins
   input  wire logic       chipSelect_n,
   input  wire logic       serialClock,
   input  wire logic       serialIn,
   input  wire logic       writeProtect_n,
   output logic            serialOut,
   output logic            serialOutEn
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] csSync;
   logic [1:0] sckSync;
   logic [1:0] siSync;
   logic [1:0] wpSync;
   logic       csPrev;
   logic       sckPrev;

   // Two flops on every pin; only stage 1 is read by logic
   always_ff @(posedge clk) begin
      if (rst) begin
         csSync  <= 2'h3;
         sckSync <= 2'h0;
         siSync  <= 2'h0;
         wpSync  <= 2'h3;
         csPrev  <= 1'b1;
         sckPrev <= 1'b0;
      end else begin
         csSync  <= {csSync[0], chipSelect_n};
         sckSync <= {sckSync[0], serialClock};
         siSync  <= {siSync[0], serialIn};
         wpSync  <= {wpSync[0], writeProtect_n};
         csPrev  <= csSync[1];
         sckPrev <= sckSync[1];
      end
   end

   // Edges of the synchronised pins; each serial clock phase must last
   // at least one clk cycle or an edge is lost
   logic selected;
   logic csRise;
   logic csFall;
   logic sckRise;
   logic sckFall;
   assign selected = ~csSync[1];
   assign csRise   = csSync[1] & ~csPrev;
   assign csFall   = ~csSync[1] & csPrev;
   // Mode 0 and mode 3 need no distinction: edges are only used while selected
   assign sckRise  = selected & ~csFall & sckSync[1] & ~sckPrev;   // R23
   assign sckFall  = selected & ~csFall & ~sckSync[1] & sckPrev;   // R23

   // ---------------------------------------------------------------
   // Array and protection decode
   // ---------------------------------------------------------------
   // Contents stay out of reset; the storage cell keeps them through power loss
   logic [7:0] memArray [0:(1 << `ADDR_W) - 1];
   logic [7:0] memReadData;

   logic                 write_enable_latch;
   logic                 bpLo;
   logic                 bpHi;
   logic                 protect_pin_enable;
   logic [`ADDR_W-1:0]   addr;

   // True when the block-protect setting covers this address
   function automatic logic isProtected(input logic [1:0] bp,
                                        input logic [`ADDR_W-1:0] a);
      case (bp)
         2'h0:    isProtected = 1'b0;                   // R6
         2'h1:    isProtected = (a >= `QUARTER_BASE);   // R6
         2'h2:    isProtected = (a >= `HALF_BASE);      // R6
         default: isProtected = 1'b1;                   // R6
      endcase
   endfunction : isProtected

   // Next sequential address; the top address rolls over to zero
   function automatic logic [`ADDR_W-1:0] nextAddr(input logic [`ADDR_W-1:0] a);
      if (a == `ADDR_LAST)
         nextAddr = `ADDR_ZERO;
      else
         nextAddr = a + 15'h0001;
   endfunction : nextAddr

   logic [7:0] statusByte;
   always_comb begin
      statusByte = 8'h00;   // R2
      statusByte[`BIT_WEL]   = write_enable_latch;
      statusByte[`BIT_BP_LO] = bpLo;
      statusByte[`BIT_BP_HI] = bpHi;
      statusByte[`BIT_PROTECT_PIN_ENABLE]  = protect_pin_enable;
   end

   logic statusLocked;
   // Pin matters only when the enable bit is set
   // The pin passes the synchroniser, so a change counts two cycles later
   assign statusLocked = protect_pin_enable & ~wpSync[1];   // R7

   // ---------------------------------------------------------------
   // Serial shifter and command sequencer
   // ---------------------------------------------------------------
   fram_pkg::phase_type phase;
   logic [2:0] bitCount;
   logic [7:0] shiftIn;
   logic [7:0] nextByte;
   logic       byteDone;
   logic       isFast;
   logic       burstStopped;
   logic       opWrite;
   logic       opStatusRead;
   logic       clearOnRise;
   logic       opcodeDone;
   logic       addrHiDone;
   logic       addrLoDone;

   assign nextByte = {shiftIn[6:0], siSync[1]};
   assign byteDone = sckRise & (bitCount == `BIT_LAST);

   // Byte-complete strobes per phase; the opcode strobe is shared by several processes
   assign opcodeDone = byteDone && phase == fram_pkg::ST_OPCODE;
   assign addrHiDone = byteDone && phase == fram_pkg::ST_ADDR_HI;
   assign addrLoDone = byteDone && phase == fram_pkg::ST_ADDR_LO;

   // Bit counter and input shift register on rising serial clock
   always_ff @(posedge clk) begin
      if (rst || csFall) begin
         bitCount <= 3'h0;
         shiftIn  <= 8'h00;
      end else if (sckRise) begin
         bitCount <= bitCount + 3'h1;
         shiftIn  <= nextByte;   // R13
      end
   end

   // A data byte is stored only with the latch set, inside the unprotected
   // range and before the burst has met a protected address; the pin has no say
   logic commitByte;
   assign commitByte = byteDone && phase == fram_pkg::ST_WRITE_DATA && write_enable_latch
                       && !burstStopped && !isProtected({bpHi, bpLo}, addr);   // R8

   // Command phase tracking; a new command only begins at select fall
   // Leaving the frame forgets the command, so a partial byte is never used
   always_ff @(posedge clk) begin
      if (rst || csFall || !selected) begin
         phase        <= fram_pkg::ST_OPCODE;
         isFast       <= 1'b0;
         burstStopped <= 1'b0;
      end else if (byteDone) begin
         case (phase)
            fram_pkg::ST_OPCODE: begin
               case (nextByte)
                  `OP_STATUS_READ:  phase <= fram_pkg::ST_READ_DATA;   // R9
                  `OP_STATUS_WRITE: phase <= fram_pkg::ST_STATUS_WR;
                  `OP_READ:         phase <= fram_pkg::ST_ADDR_HI;     // R17
                  `OP_WRITE:        phase <= fram_pkg::ST_ADDR_HI;     // R13
                  `OP_FAST_READ: begin
                     phase  <= fram_pkg::ST_ADDR_HI;                   // R19
                     isFast <= 1'b1;
                  end
                  default:          phase <= fram_pkg::ST_IGNORE;      // R24
               endcase
            end
            fram_pkg::ST_ADDR_HI: phase <= fram_pkg::ST_ADDR_LO;
            // Fast read takes a dummy byte before its data
            fram_pkg::ST_ADDR_LO: begin
               if (isFast)
                  phase <= fram_pkg::ST_DUMMY;                         // R19
               else if (opWrite)
                  phase <= fram_pkg::ST_WRITE_DATA;
               else
                  phase <= fram_pkg::ST_READ_DATA;
            end
            fram_pkg::ST_DUMMY:   phase <= fram_pkg::ST_READ_DATA;     // R19
            fram_pkg::ST_WRITE_DATA: begin
               if (write_enable_latch && isProtected({bpHi, bpLo}, addr))
                  burstStopped <= 1'b1;                                // R16
            end
            fram_pkg::ST_STATUS_WR: phase <= fram_pkg::ST_IGNORE;
            default: phase <= phase;
         endcase
      end
   end

   // Opcode held for the frame, needed to tell a write from a read
   always_ff @(posedge clk) begin
      if (rst || csFall) begin
         opWrite      <= 1'b0;
         opStatusRead <= 1'b0;
      end else if (opcodeDone) begin
         opWrite      <= (nextByte == `OP_WRITE);
         opStatusRead <= (nextByte == `OP_STATUS_READ);
      end
   end

   // Address counter: loads from the address bytes, advances per array read byte and per stored write byte
   always_ff @(posedge clk) begin
      if (rst) begin
         addr <= `ADDR_ZERO;
      end else if (addrHiDone) begin
         addr <= {nextByte[6:0], addr[7:0]};                   // R13
      end else if (addrLoDone) begin
         addr <= {addr[`ADDR_W-1:8], nextByte};
      end else if (byteDone && phase == fram_pkg::ST_READ_DATA && !opStatusRead) begin
         addr <= nextAddr(addr);                               // R17 R20
      end else if (commitByte) begin
         addr <= nextAddr(addr);                               // R14
      end
   end

   // Array store, one byte at its eighth bit; no page buffer
   always_ff @(posedge clk) begin
      if (commitByte)
         memArray[addr] <= nextByte;                           // R15
   end
   assign memReadData = memArray[addr];

   // ---------------------------------------------------------------
   // Write enable latch and status register
   // ---------------------------------------------------------------
   // Remembers which command must drop the latch at select rise
   always_ff @(posedge clk) begin
      if (rst || csFall) begin
         clearOnRise <= 1'b0;
      end else if (opcodeDone) begin
         clearOnRise <= (nextByte == `OP_LATCH_CLEAR) ||
                        (nextByte == `OP_STATUS_WRITE) ||
                        (nextByte == `OP_WRITE);                 // R22
      end
   end

   logic setOnRise;
   always_ff @(posedge clk) begin
      if (rst || csFall)
         setOnRise <= 1'b0;
      else if (opcodeDone)
         setOnRise <= (nextByte == `OP_LATCH_SET);              // R21
   end

   // Latch acts at select rise so the whole frame sees one value
   // Set and clear never meet: a frame carries one opcode only
   always_ff @(posedge clk) begin
      if (rst)
         write_enable_latch <= 1'b0;                                          // R3
      else if (csRise && setOnRise)
         write_enable_latch <= 1'b1;                                          // R4
      else if (csRise && clearOnRise)
         write_enable_latch <= 1'b0;                                          // R1 R10 R22
   end

   // Protection bits; reset stands in for the shipped value, power loss
   // retention belongs to the storage cell underneath
   always_ff @(posedge clk) begin
      if (rst) begin
         bpLo <= 1'b0;                                         // R5
         bpHi <= 1'b0;
         protect_pin_enable <= 1'b0;
      end else if (byteDone && phase == fram_pkg::ST_STATUS_WR
                   && write_enable_latch && !statusLocked) begin
         bpLo <= nextByte[`BIT_BP_LO];                         // R10
         bpHi <= nextByte[`BIT_BP_HI];
         protect_pin_enable <= nextByte[`BIT_PROTECT_PIN_ENABLE];                          // R7
      end
   end

   // ---------------------------------------------------------------
   // Serial output
   // ---------------------------------------------------------------
   logic [7:0] shiftOut;
   logic       driving;
   logic       loadPoint;
   logic       statusSent;
   // Falling clock that opens a new output byte
   assign loadPoint = sckFall && phase == fram_pkg::ST_READ_DATA && bitCount == 3'h0;

   // Output changes on falling clock; first bit loaded at the fall after the byte's last rise
   always_ff @(posedge clk) begin
      if (rst || !selected) begin
         shiftOut <= 8'h00;
         driving  <= 1'b0;                                     // R18
      end else if (loadPoint) begin
         shiftOut <= opStatusRead ? statusByte : memReadData;  // R9 R17 R20
         driving  <= 1'b1;
      end else if (sckFall && driving) begin
         shiftOut <= {shiftOut[6:0], 1'b0};                    // R23
      end
   end

   // A status read carries one byte: its second load point ends the drive
   always_ff @(posedge clk) begin
      if (rst || !selected) begin
         statusSent <= 1'b0;
      end else if (loadPoint && opStatusRead && driving) begin
         statusSent <= 1'b1;                                   // R9
      end
   end

   // Status read gives exactly one byte, then the line floats
   always_ff @(posedge clk) begin
      if (rst) begin
         serialOut   <= 1'b0;
         serialOutEn <= 1'b0;
      end else begin
         serialOut   <= shiftOut[7];
         serialOutEn <= driving && !statusSent;                // R9 R18
      end
   end

endmodule : spi_fram_protect_and_access

// ### testbench/spi_fram_asserts.sv
// Pin-level checks on the serial memory slave
`timescale 1ns/1ps
module spi_fram_asserts (
   // System
   input wire logic clk,
   input wire logic rst,
   // Serial link pins
   input wire logic chipSelect_n,
   input wire logic serialClock,
   input wire logic serialIn,
   input wire logic serialOut,
   input wire logic serialOutEn
);
   logic       sckLast;
   logic [5:0] rises;
   logic [7:0] opcode;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Frame tracking
   // ----------------------------------------
   // Raw edges are counted at once; the design sees them a few cycles later
   always_ff @(posedge clk) begin
      sckLast <= serialClock;
   end
   always_ff @(posedge clk) begin
      if (rst || chipSelect_n) begin
         rises <= 6'h00;
      end else if (serialClock && !sckLast && rises != 6'h3f) begin
         rises <= rises + 6'h01;
      end
   end
   // First byte of the frame is the opcode
   always_ff @(posedge clk) begin
      if (rst || chipSelect_n) begin
         opcode <= 8'h00;
      end else if (serialClock && !sckLast && rises < 6'h08) begin
         opcode <= {opcode[6:0], serialIn};
      end
   end

   reset_quiet_a: assert property ($fell(rst) |-> !serialOutEn && !serialOut)
      else $error("output driven right after reset");
   deselect_float_a: assert property ($rose(chipSelect_n) |-> ##[1:8] !serialOutEn)
      else $error("output still driven after deselect");
   idle_float_a: assert property (chipSelect_n [*8] |-> !serialOutEn)
      else $error("output driven while deselected");
   status_start_a: assert property ($rose(serialOutEn) && opcode == 8'h05 |->
      rises inside {[6'h08:6'h09]}) else $error("status byte starts at wrong bit");
   read_start_a: assert property ($rose(serialOutEn) && opcode == 8'h03 |->
      rises inside {[6'h18:6'h19]}) else $error("read data starts at wrong bit");
   fast_start_a: assert property ($rose(serialOutEn) && opcode == 8'h0b |->
      rises inside {[6'h20:6'h21]}) else $error("fast read latency wrong");
   known_op_a: assert property (serialOutEn && !chipSelect_n |->
      opcode inside {8'h05, 8'h03, 8'h0b}) else $error("drive after silent opcode");
   status_once_a: assert property (serialOutEn && !chipSelect_n && opcode == 8'h05 |->
      rises <= 6'h11) else $error("status byte repeated");
   out_edge_a: assert property ($fell(serialClock) && serialOutEn |=> $stable(serialOut) [*2])
      else $error("output changed too soon after falling clock");

   status_seen_c: cover property ($rose(serialOutEn) && opcode == 8'h05);
   read_seen_c: cover property ($rose(serialOutEn) && opcode == 8'h03);
   fast_seen_c: cover property ($rose(serialOutEn) && opcode == 8'h0b);
endmodule : spi_fram_asserts

bind spi_fram_protect_and_access spi_fram_asserts checker_inst (.clk(clk), .rst(rst),
   .chipSelect_n(chipSelect_n), .serialClock(serialClock), .serialIn(serialIn),
   .serialOut(serialOut), .serialOutEn(serialOutEn));

// ### testbench/spi_master_model.sv
// Bus master model for the serial link, modes 0 and 3
`timescale 1ns/1ps
module spi_master_model (
   // System
   input  wire logic clk,
   // Serial link pins
   input  wire logic serialOut,
   input  wire logic serialOutEn,
   output logic      chipSelect_n,
   output logic      serialClock,
   output logic      serialIn
);
   logic       lastOut;
   logic       miso;
   logic       idleHigh;

   // A released line shows the inverse of its last level, so stale data never matches
   always @(posedge clk) begin
      if (serialOutEn) begin
         lastOut <= serialOut;
      end
   end
   assign miso = serialOutEn ? serialOut : ~lastOut;

   initial begin
      chipSelect_n = 1'b1;
      serialClock  = 1'b0;
      serialIn     = 1'b0;
      lastOut      = 1'b0;
      idleHigh     = 1'b0;
   end

   // ----------------------------------------
   // One frame per command, clock idles at the mode's level
   // ----------------------------------------
   // Clock idle level between frames: low for mode 0, high for mode 3
   task automatic set_mode(input logic high);
      idleHigh    = high;
      serialClock = high;
   endtask : set_mode
   // Input is read late in the high phase, where the bit stands
   task automatic frame(input logic [7:0] tx [$], output logic [7:0] rx [$]);
      logic [7:0] b;
      rx = {};
      @(posedge clk);
      #1 chipSelect_n = 1'b0;
      foreach (tx[i]) begin
         for (int j = 7; j >= 0; j--) begin
            if (idleHigh)
               serialClock = 1'b0;
            serialIn = tx[i][j];
            repeat (4) @(posedge clk);
            #1 serialClock = 1'b1;
            repeat (4) @(posedge clk);
            #1 b[j] = miso;
            if (!idleHigh)
               serialClock = 1'b0;
         end
         rx.push_back(b);
      end
      repeat (4) @(posedge clk);
      #1 chipSelect_n = 1'b1;
      repeat (8) @(posedge clk);
      #1;
   endtask : frame
endmodule : spi_master_model

// ### testbench/tb.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
module tb;
   logic       clk;
   logic       rst;
   logic       writeProtect_n;
   logic       chipSelect_n;
   logic       serialClock;
   logic       serialIn;
   logic       serialOut;
   logic       serialOutEn;
   int         fails;
   int         n_compared;
   int         cycles;
   logic [7:0] rx [$];

   spi_fram_protect_and_access DUT (.clk(clk), .rst(rst), .chipSelect_n(chipSelect_n),
      .serialClock(serialClock), .serialIn(serialIn), .writeProtect_n(writeProtect_n),
      .serialOut(serialOut), .serialOutEn(serialOutEn));
   spi_master_model master (.clk(clk), .serialOut(serialOut), .serialOutEn(serialOutEn),
      .chipSelect_n(chipSelect_n), .serialClock(serialClock), .serialIn(serialIn));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Ceiling far above the few thousand cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         finish_test();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic send(input logic [7:0] tx [$]);
      master.frame(tx, rx);
   endtask : send
   task automatic status(input logic [7:0] mask, input logic [7:0] exp);
      send({8'h05, 8'h00});
      check(rx[1] & mask, exp);
   endtask : status
   task automatic finish_test;
      if (fails == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_status;
      status(8'hff, 8'h00);
      send({8'h06});
      send({8'h01, 8'hff});
      status(8'hff, 8'h8c);
      send({8'h06});
      status(8'hff, 8'h8e);
      send({8'h04});
      status(8'hff, 8'h8c);
      writeProtect_n = 1'b0;
      send({8'h06});
      send({8'h01, 8'h00});
      status(8'h8c, 8'h8c);
      writeProtect_n = 1'b1;
      send({8'h06});
      send({8'h01, 8'h00});
      status(8'hff, 8'h00);
   endtask : t_status
   // Pin held low from here: it must never block array writes
   task automatic t_wrap;
      writeProtect_n = 1'b0;
      send({8'h06});
      send({8'h02, 8'hff, 8'hfe, 8'h01, 8'h02, 8'h03});
      status(8'hff, 8'h00);
      send({8'h06});
      send({8'h02, 8'h3f, 8'hff, 8'ha1, 8'ha2});
      send({8'h06});
      send({8'h02, 8'h5f, 8'hff, 8'hb1, 8'hb2});
      send({8'h02, 8'h00, 8'h00, 8'h5a});
      send({8'h03, 8'hff, 8'hfe, 8'hff, 8'hff, 8'hff});
      check(rx[3], 8'h01);
      check(rx[4], 8'h02);
      check(rx[5], 8'h03);
      send({8'h0b, 8'h7f, 8'hff, 8'h00, 8'hff, 8'hff});
      check(rx[4], 8'h02);
      check(rx[5], 8'h03);
      master.set_mode(1'b1);
      send({8'h03, 8'h7f, 8'hfe, 8'h00, 8'h00});
      check(rx[3], 8'h01);
      check(rx[4], 8'h02);
      master.set_mode(1'b0);
   endtask : t_wrap
   task automatic t_protect;
      logic [15:0] start [3] = '{16'h5fff, 16'h3fff, 16'h7fff};
      logic [7:0]  old [3]   = '{8'hb2, 8'ha2, 8'h03};
      for (int k = 1; k <= 3; k++) begin
         send({8'h06});
         send({8'h01, 8'(k << 2)});
         send({8'h06});
         send({8'h02, start[k-1][15:8], start[k-1][7:0], 8'h55, 8'h66});
         send({8'h03, start[k-1][15:8], start[k-1][7:0], 8'h00, 8'h00});
         check(rx[3], (k == 3) ? 8'h02 : 8'h55);
         check(rx[4], old[k-1]);
      end
   endtask : t_protect
   task automatic t_unknown;
      send({8'h9f, 8'h01, 8'h00});
      status(8'hff, 8'h0c);
      send({8'h05, 8'h00, 8'h00});
      check(rx[1], 8'h0c);
      check(rx[2], 8'hff);
   endtask : t_unknown

   initial begin
      rst = 1'b1;
      writeProtect_n = 1'b1;
      fails = 0;
      n_compared = 0;
      cycles = 0;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      t_status();
      t_wrap();
      t_protect();
      t_unknown();
      finish_test();
   end
endmodule : tb
